// file: amc_host_model.sv
// amc_host_model: serial host driving the mode block pins.
// assumes a 125 MHz sys_clk; sclk idles high between frames.
`timescale 1ns/100ps

module amc_host_model (
  // clock
  input  wire logic sys_clk,
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  ////////////////////////////////////////////////////////////////////////
  // six-cycle half periods stay clear of the four-cycle minimum
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk <= 1'b0;
      sdi  <= tx[i];
      tick(5);
      @(negedge sys_clk);
      rx[i] = sdo;
      tick(1);
      sclk <= 1'b1;
      tick(6);
    end
  endtask : xfer

  task automatic frame(input logic [7:0] cmd, input logic [7:0] d, output logic [7:0] rx);
    logic [7:0] junk;
    cs_n <= 1'b0;
    tick(2);
    xfer(cmd, junk);
    xfer(d, rx);
    cs_n <= 1'b1;
    // released line must not keep the last bit
    sdi  <= ~d[0];
    tick(4);
  endtask : frame
endmodule : amc_host_model

// file: amc_mode_ctrl.sv
// amc_mode_ctrl: operating-mode register of a dual sigma-delta converter,
// its serial access path and the mode sequencing it drives.
// assumes serial pins asynchronous to sys_clk and sclk well below sys_clk/4.
//
// Function
// - eight-bit read/write mode register at address 1, zero after reset
// - serial transfers of the register run bit 7 first
// - bits 7 and 5 reserved, held at zero
// - bit 6 set bypasses the main front-end buffer
// - bit 4 set selects three pseudo-differential main inputs, drops shared pair
// - bit 4 clear leaves auxiliary differential or single-ended input choice
// - bit 3 set stops oscillator in standby; 300 ms start-up on exit
// - bit 3 clear keeps oscillator running in standby, no start-up wait
// - bits 2..0 select the operating mode of the enabled converters
// - mode zero turns off excitation sources and PLL
// - idle holds filter and modulator reset, modulator clocks running
// - single conversion returns mode field to idle when done
// - continuous conversion keeps running without leaving the mode
// - every mode-field write resets both converters, even unchanged
// - calibration codes clear ready flags, run, then return to idle
`timescale 1ns/100ps

module amc_mode_ctrl
  import amc_pkg::*;
#(
  parameter int unsigned START_CYC = 32'(STARTUP_CYC)
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // serial pins from the host
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  // converter side
  input  wire logic       standby_n,
  input  wire logic       conv_done,
  input  wire logic       cal_done,
  output logic            adc_reset,
  output logic            clear_ready,
  output logic            buffer_bypass,
  output logic            input_topology_select,
  output logic            shared_input_pair_en,
  output logic            pll_enable,
  output logic            excitation_enable,
  output logic            modulator_hold,
  output logic            convert_run,
  output logic            calibrate_run,
  output logic [2:0]      operating_mode_field,
  output logic            osc_enable,
  output logic            osc_ready
);

  // elaboration check: the start-up counter must hold START_CYC
  if (START_CYC < 1 || START_CYC >= (32'd1 << STARTUP_W)) begin : g_bad_start
    $error("START_CYC out of range for the start-up counter");
  end

  typedef struct packed {
    logic       sclk_m, sclk_s, sclk_d;
    logic       sdi_m,  sdi_s;
    logic       csn_m,  csn_s;
    logic       sby_m,  sby_s;
    amc_phase_t phase;
    logic [3:0] bit_cnt;
    logic       rd, hit;
    logic [7:0] shin, shout;
    logic [7:0] mode_reg;
    logic       sdo, sdo_oe;
    logic       adc_reset, clear_ready;
    logic       buf_byp, topo, shared_en, pll_en, exc_en, mod_hold, conv_run, cal_run;
    logic       osc_en, osc_ready;
    logic [STARTUP_W-1:0] start_cnt;
  } amc_state_t;

  amc_state_t r, next_r;
  logic       wr_commit;

  function automatic logic is_cal(input logic [2:0] md);
    return md[MODE_CAL_BIT];
  endfunction : is_cal

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic       rise, fall;
    logic [7:0] byte_in;
    logic [2:0] md;
    rise      = 1'b0;
    fall      = 1'b0;
    byte_in   = 8'h00;
    md        = 3'h0;
    wr_commit = 1'b0;
    next_r    = r;
    next_r.adc_reset   = 1'b0;
    next_r.clear_ready = 1'b0;
    // two-flop synchronisers, edges taken from second and third stage only
    next_r.sclk_m = sclk;
    next_r.sclk_s = r.sclk_m;
    next_r.sclk_d = r.sclk_s;
    next_r.sdi_m  = sdi;
    next_r.sdi_s  = r.sdi_m;
    next_r.csn_m  = cs_n;
    next_r.csn_s  = r.csn_m;
    next_r.sby_m  = standby_n;
    next_r.sby_s  = r.sby_m;
    rise = r.sclk_s & ~r.sclk_d;
    fall = ~r.sclk_s & r.sclk_d;
    byte_in = {r.shin[6:0], r.sdi_s};

    if (r.csn_s) begin
      // deselect realigns framing to a fresh communications byte
      next_r.phase   = SP_COMM;
      next_r.bit_cnt = 4'h0;
    end else if (rise) begin
      next_r.shin    = byte_in;
      next_r.bit_cnt = r.bit_cnt + 4'h1;
      if (r.bit_cnt == BIT_LAST) begin
        next_r.bit_cnt = 4'h0;
        if (r.phase == SP_COMM) begin
          if (!byte_in[COMM_WEN_BIT]) begin
            next_r.phase = SP_DATA;
            next_r.rd    = byte_in[COMM_RD_BIT];
            next_r.hit   = (byte_in[COMM_ADDR_MSB:0] == ADDR_OP_MODE);
            next_r.shout = r.mode_reg;
          end
        end else begin
          next_r.phase = SP_COMM;
          wr_commit    = r.hit & ~r.rd;
        end
      end
    end else if (fall && r.phase == SP_DATA && r.bit_cnt != 4'h0) begin
      next_r.shout = {r.shout[6:0], 1'b0};
    end
    next_r.sdo_oe = ~r.csn_s & (next_r.phase == SP_DATA) & next_r.rd & next_r.hit;
    next_r.sdo    = next_r.shout[BYTE_BITS-1];

    ////////////////////////////////////////////////////////////////////////
    // mode register: host write beats hardware return to idle
    if (wr_commit) begin
      next_r.mode_reg  = byte_in & OP_MODE_WMASK;
      next_r.adc_reset = 1'b1;
      next_r.clear_ready = is_cal(byte_in[MODE_FIELD_MSB:0])
                           | (byte_in[MODE_FIELD_MSB:0] == MODE_SINGLE)
                           | (byte_in[MODE_FIELD_MSB:0] == MODE_CONTINUOUS);
    end else if ((r.mode_reg[MODE_FIELD_MSB:0] == MODE_SINGLE && conv_done)
              || (is_cal(r.mode_reg[MODE_FIELD_MSB:0]) && cal_done)) begin
      next_r.mode_reg[MODE_FIELD_MSB:0] = MODE_IDLE;
    end

    md = next_r.mode_reg[MODE_FIELD_MSB:0];
    next_r.buf_byp   = next_r.mode_reg[BIT_BUF_BYPASS];
    next_r.topo      = next_r.mode_reg[BIT_TOPOLOGY];
    next_r.shared_en = ~next_r.mode_reg[BIT_TOPOLOGY];
    next_r.pll_en    = (md != MODE_POWER_DOWN);
    next_r.exc_en    = (md != MODE_POWER_DOWN);
    next_r.mod_hold  = (md == MODE_IDLE) | (md == MODE_POWER_DOWN) | ~next_r.osc_ready;
    next_r.conv_run  = ((md == MODE_SINGLE) | (md == MODE_CONTINUOUS)) & next_r.osc_ready;
    next_r.cal_run   = is_cal(md) & next_r.osc_ready;

    ////////////////////////////////////////////////////////////////////////
    // oscillator stop in standby and start-up wait on the way out
    next_r.osc_en = ~(~r.sby_s & next_r.mode_reg[BIT_OSC_STOP]);
    if (!next_r.osc_en) begin
      next_r.osc_ready = 1'b0;
      next_r.start_cnt = STARTUP_W'(START_CYC);
    end else if (!r.osc_ready) begin
      if (r.start_cnt == '0)
        next_r.osc_ready = 1'b1;
      else
        next_r.start_cnt = r.start_cnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      r           <= '0;
      // sclk idles high: a low reset value would fake a rising edge
      r.sclk_m    <= 1'b1;
      r.sclk_s    <= 1'b1;
      r.sclk_d    <= 1'b1;
      r.csn_m     <= 1'b1;
      r.csn_s     <= 1'b1;
      r.sby_m     <= 1'b1;
      r.sby_s     <= 1'b1;
      r.phase     <= SP_COMM;
      r.mode_reg  <= OP_MODE_RESET;
      r.mod_hold  <= 1'b1;
      r.shared_en <= 1'b1;
      r.osc_en    <= 1'b1;
      r.osc_ready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign sdo                   = r.sdo;
  assign sdo_oe                = r.sdo_oe;
  assign adc_reset             = r.adc_reset;
  assign clear_ready           = r.clear_ready;
  assign buffer_bypass         = r.buf_byp;
  assign input_topology_select = r.topo;
  assign shared_input_pair_en  = r.shared_en;
  assign pll_enable            = r.pll_en;
  assign excitation_enable     = r.exc_en;
  assign modulator_hold        = r.mod_hold;
  assign convert_run           = r.conv_run;
  assign calibrate_run         = r.cal_run;
  assign operating_mode_field  = r.mode_reg[MODE_FIELD_MSB:0];
  assign osc_enable            = r.osc_en;
  assign osc_ready             = r.osc_ready;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_reset_zero: assert property ($past(!rstn) |-> r.mode_reg == 8'h00)
    else $error("mode register not zero after reset");
  chk_reserved_bits: assert property (!r.mode_reg[7] && !r.mode_reg[5])
    else $error("reserved mode bit set");
  chk_write_resets: assert property (wr_commit |=> adc_reset ##1 !adc_reset)
    else $error("mode write did not pulse converter reset");
  chk_single_to_idle: assert property (r.mode_reg[2:0] == MODE_SINGLE && conv_done
    && !wr_commit |=> operating_mode_field == MODE_IDLE) else $error("single did not return idle");
  chk_cal_to_idle: assert property (r.mode_reg[2] && cal_done && !wr_commit
    |=> operating_mode_field == MODE_IDLE) else $error("calibration did not return idle");
  chk_cal_clears: assert property (wr_commit && is_cal({r.shin[1:0], r.sdi_s}) |=> clear_ready)
    else $error("calibration write did not clear ready");
  chk_powerdown_off: assert property (operating_mode_field == MODE_POWER_DOWN
    |-> !pll_enable && !excitation_enable) else $error("power-down left PLL or sources on");
  chk_idle_hold: assert property (operating_mode_field == MODE_IDLE |-> modulator_hold)
    else $error("idle without modulator hold");
  chk_cont_stays: assert property (operating_mode_field == MODE_CONTINUOUS && !wr_commit
    |=> operating_mode_field == MODE_CONTINUOUS) else $error("continuous mode left by itself");
  chk_osc_stop: assert property (!r.sby_s && r.mode_reg[3] |=> !osc_enable ##1 !osc_ready)
    else $error("oscillator not stopped in standby");
  chk_osc_keep: assert property (!r.mode_reg[3] && osc_ready |=> osc_enable && osc_ready)
    else $error("oscillator stopped without stop bit");
  chk_buffer_sel: assert property (buffer_bypass == r.mode_reg[6])
    else $error("buffer select mismatch");

endmodule : amc_mode_ctrl

// file: amc_mode_ctrl_tb.sv
// amc_mode_ctrl_tb: checks the mode register and sequencing.
// assumes amc_host_model as the serial host; short start-up count.
`timescale 1ns/100ps

module amc_mode_ctrl_tb;
  import amc_pkg::*;
  localparam int SC = 20;
  logic        sys_clk, rstn, standby_n, conv_done, cal_done;
  logic        sclk, cs_n, sdi, sdo, sdo_oe, adc_reset, clear_ready;
  logic        buffer_bypass, input_topology_select, shared_input_pair_en;
  logic        pll_enable, excitation_enable, modulator_hold, convert_run;
  logic        calibrate_run, osc_enable, osc_ready;
  logic [2:0]  operating_mode_field;
  logic        sdo_line;
  logic [7:0]  mdl, rx;
  logic [31:0] seed;
  int          miscompares, tests_run, resets, clears, r0, c0, n;

  amc_mode_ctrl #(.START_CYC(SC)) amc_mode_ctrl_inst (
    .sys_clk(sys_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .standby_n(standby_n), .conv_done(conv_done),
    .cal_done(cal_done), .adc_reset(adc_reset), .clear_ready(clear_ready),
    .buffer_bypass(buffer_bypass), .input_topology_select(input_topology_select),
    .shared_input_pair_en(shared_input_pair_en), .pll_enable(pll_enable),
    .excitation_enable(excitation_enable), .modulator_hold(modulator_hold),
    .convert_run(convert_run), .calibrate_run(calibrate_run),
    .operating_mode_field(operating_mode_field), .osc_enable(osc_enable),
    .osc_ready(osc_ready)
  );
  // undriven line reads as the inverse, so a late or missing enable shows up
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  amc_host_model host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_line));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (adc_reset === 1'b1) resets++;
    if (clear_ready === 1'b1) clears++;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic got, input logic exp);
    chk_reg({7'h00, got}, {7'h00, exp});
  endtask : chk_pin

  task automatic wr(input logic [7:0] v);
    host.frame(8'h01, v, rx);
    mdl = v & OP_MODE_WMASK;
    host.tick(4);
  endtask : wr

  task automatic pulse(input logic cal);
    if (cal) cal_done <= 1'b1;
    else conv_done <= 1'b1;
    host.tick(1);
    {cal_done, conv_done} <= 2'b00;
    host.tick(3);
  endtask : pulse

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, standby_n, conv_done, cal_done} = 4'h4;
    seed = 32'h91d9;
    host.tick(4);
    rstn <= 1'b1;
    host.tick(2);
    host.frame(8'h41, 8'h00, rx);
    chk_reg(rx, OP_MODE_RESET);
    chk_pin(pll_enable, 1'b0);
    chk_pin(excitation_enable, 1'b0);
    $display("test reset finished");
    // reserved bits written as one on purpose
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      wr((seed[7:0] & 8'hF0) | 8'hA1);
      host.frame(8'h41, 8'h00, rx);
      chk_reg(rx, mdl);
      chk_pin(buffer_bypass, mdl[6]);
      chk_pin(input_topology_select, mdl[4]);
      chk_pin(shared_input_pair_en, ~mdl[4]);
      chk_pin(modulator_hold, 1'b1);
    end
    $display("test fields finished");
    // mid-run reset with a non-zero register
    rstn <= 1'b0;
    host.tick(4);
    rstn <= 1'b1;
    host.tick(2);
    host.frame(8'h41, 8'h00, rx);
    chk_reg(rx, OP_MODE_RESET);
    chk_pin(shared_input_pair_en, 1'b1);
    chk_pin(pll_enable, 1'b0);
    $display("test mid-run reset finished");
    for (int m = 0; m < 8; m++) begin
      r0 = resets;
      c0 = clears;
      wr(8'(m));
      wr(8'(m));
      chk_reg(8'(resets - r0), 8'h02);
      chk_reg(8'(clears - c0), (m >= 2) ? 8'h02 : 8'h00);
      chk_pin(pll_enable, m != 0);
      chk_reg({5'h00, operating_mode_field}, mdl);
      if (m == 2 || m == 3) chk_pin(convert_run, 1'b1);
      if (m >= 4) chk_pin(calibrate_run, 1'b1);
      if (m >= 2) pulse(m >= 4);
      if (m == 2 || m >= 4) mdl = 8'h01;
      host.frame(8'h41, 8'h00, rx);
      chk_reg(rx, mdl);
    end
    $display("test modes finished");
    for (int os = 1; os >= 0; os--) begin
      wr(8'h01 | 8'(os << 3));
      standby_n <= 1'b0;
      host.tick(6);
      chk_pin(osc_enable, os == 0);
      chk_pin(osc_ready, os == 0);
      standby_n <= 1'b1;
      n = 0;
      while (osc_ready !== 1'b1 && n < 200) begin
        host.tick(1);
        n++;
      end
      if (n == 200) begin
        miscompares++;
        give_verdict;
      end
      chk_pin(os ? (n >= SC + 3 && n <= SC + 5) : (n == 0), 1'b1);
    end
    $display("test standby finished");
    give_verdict;
  end
endmodule : amc_mode_ctrl_tb

// file: amc_pkg.sv
// amc_pkg: register map, field layout, mode codes and timing of the
// operating-mode control block. assumes a 125 MHz system clock.
package amc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // serial framing
  localparam int          BYTE_BITS     = 8;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam int          COMM_WEN_BIT  = 7;
  localparam int          COMM_RD_BIT   = 6;
  localparam int          COMM_ADDR_MSB = 3;
  localparam logic [3:0]  ADDR_OP_MODE  = 4'h1;

  ////////////////////////////////////////////////////////////////////////
  // operating_mode register layout
  localparam logic [7:0]  OP_MODE_RESET = 8'h00;
  localparam logic [7:0]  OP_MODE_WMASK = 8'h5F;
  localparam int          BIT_BUF_BYPASS  = 6;
  localparam int          BIT_TOPOLOGY    = 4;
  localparam int          BIT_OSC_STOP    = 3;
  localparam int          MODE_FIELD_MSB  = 2;
  localparam int          MODE_CAL_BIT    = 2;

  localparam logic [2:0]  MODE_POWER_DOWN = 3'h0;
  localparam logic [2:0]  MODE_IDLE       = 3'h1;
  localparam logic [2:0]  MODE_SINGLE     = 3'h2;
  localparam logic [2:0]  MODE_CONTINUOUS = 3'h3;

  ////////////////////////////////////////////////////////////////////////
  // oscillator start-up after standby
  localparam longint unsigned CLK_HZ       = 64'd125_000_000;
  localparam longint unsigned STARTUP_MS   = 64'd300;
  localparam longint unsigned STARTUP_CYC  = (STARTUP_MS * CLK_HZ) / 64'd1000;
  localparam int              STARTUP_W    = 26;

  typedef enum logic [1:0] {
    SP_COMM = 2'b01,
    SP_DATA = 2'b10
  } amc_phase_t;

endpackage : amc_pkg
